//--- verilog/afc_defs.svh
// Constants for the strobe-driven buffer controller.
// Assumes a 100 MHz sys_clk.
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH
`define AFC_CLK_NS 10
`define AFC_PULSE_NS 50
`define AFC_RECOV_NS 20
`define AFC_PULSE_CYC ((`AFC_PULSE_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RECOV_CYC ((`AFC_RECOV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_REG_CTRL 32'h0000_0000
`define AFC_REG_WDATA 32'h0000_0004
`define AFC_REG_RDATA 32'h0000_0008
`define AFC_REG_STATUS 32'h0000_000c
`define AFC_CTRL_WRITE 0
`define AFC_CTRL_READ 1
`define AFC_CTRL_RESET 2
`define AFC_CTRL_REWIND 3
`define AFC_CTRL_CASCADE 4
`define AFC_CTRL_FIRST 5
`define AFC_CTRL_OE 6
`define AFC_RESP_OKAY 2'b00
`define AFC_RESP_SLVERR 2'b10
`endif

//--- verilog/afc_pkg.sv
// Types for the strobe-driven buffer controller.
// Assumes afc_defs.svh is available on the include path.
package afc_pkg;
    typedef enum logic [2:0] {
        AFC_IDLE, AFC_ASSERT, AFC_RECOVER
    } afc_phase_t;
    typedef enum logic [1:0] {
        AFC_OP_WRITE, AFC_OP_READ, AFC_OP_RESET, AFC_OP_REWIND
    } afc_op_t;
    typedef struct packed {
        logic full_n;
        logic empty_n;
        logic near_n;
        logic half_n;
    } afc_flags_t;
    typedef struct packed {
        logic write_n;
        logic read_n;
        logic reset_n;
        logic rewind_n;
        logic oe_n;
        logic cascade_n;
        logic [8:0] data;
    } afc_pins_t;
endpackage

//--- verilog/afc_sync.sv
// Two-flop synchroniser for the device's status pins and data outputs.
// Assumes inputs come from outside the sys_clk domain.
`timescale 1ns/100ps
module afc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } afc_sync_st_t;
    afc_sync_st_t st_q;
    afc_sync_st_t st_d;
    always_comb begin
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign sync_out = st_q.s2;
endmodule // afc_sync

//--- verilog/afc_host.sv
// Controller that drives a strobe-controlled asynchronous buffer.
// Assumes AXI4-Lite software access and the device pins on one board.
`timescale 1ns/100ps
`include "afc_defs.svh"
module afc_host
    import afc_pkg::*;
#(
    parameter int PULSE_CYC = `AFC_PULSE_CYC,
    parameter int RECOV_CYC = `AFC_RECOV_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic write_n,
    output logic read_n,
    output logic master_reset_n,
    output logic first_load_rewind_n,
    output logic oe_n,
    output logic cascade_in_n,
    output logic [8:0] push_data,
    input wire logic [8:0] pop_data,
    input wire logic full_flag_n,
    input wire logic empty_flag_n,
    input wire logic near_limit_flag_n,
    input wire logic cascade_out_half_n
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        afc_phase_t phase;
        afc_op_t op;
        logic [15:0] cnt;
        logic pending;
        logic busy;
        logic cascade;
        logic first;
        logic oe_q;
        logic reset_done;
        logic [8:0] last_pop;
        logic blocked;
        afc_pins_t pins;
    } afc_st_t;
    afc_st_t st_q;
    afc_st_t st_d;
    logic [12:0] sync_bus;
    afc_flags_t flags;
    logic [8:0] pop_s;
    afc_sync #(
        .WIDTH(13)
    ) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .async_in({full_flag_n, empty_flag_n, near_limit_flag_n, cascade_out_half_n, pop_data}),
        .sync_out(sync_bus)
    );
    assign flags = afc_flags_t'(sync_bus[12:9]);
    assign pop_s = sync_bus[8:0];
    function automatic logic [31:0] status_word(input afc_st_t s, input afc_flags_t f);
        status_word = {16'h0000, s.last_pop, s.blocked, s.reset_done, s.busy,
            f.full_n, f.empty_n, f.near_n, f.half_n};
    endfunction
    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (s_axi_awvalid && !st_q.aw_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got && !st_q.bvalid) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = `AFC_RESP_OKAY;
            unique case (st_q.awaddr[7:0])
                8'(`AFC_REG_CTRL): begin
                    st_d.cascade = st_q.wdata[`AFC_CTRL_CASCADE];
                    st_d.first = st_q.wdata[`AFC_CTRL_FIRST];
                    st_d.oe_q = st_q.wdata[`AFC_CTRL_OE];
                    if (!st_q.busy && !st_q.pending && |st_q.wdata[3:0]) begin
                        st_d.pending = 1'b1;
                        // Reset outranks rewind, rewind outranks read and write.
                        if (st_q.wdata[`AFC_CTRL_RESET]) begin
                            st_d.op = AFC_OP_RESET;
                        end else if (st_q.wdata[`AFC_CTRL_REWIND]) begin
                            st_d.op = AFC_OP_REWIND;
                        end else if (st_q.wdata[`AFC_CTRL_READ]) begin
                            st_d.op = AFC_OP_READ;
                        end else begin
                            st_d.op = AFC_OP_WRITE;
                        end
                    end
                end
                8'(`AFC_REG_WDATA): st_d.pins.data = st_q.wdata[8:0];
                default: st_d.bresp = `AFC_RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = `AFC_RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                8'(`AFC_REG_CTRL): st_d.rdata = {25'h0, st_q.oe_q, st_q.first, st_q.cascade, 4'h0};
                8'(`AFC_REG_WDATA): st_d.rdata = {23'h0, st_q.pins.data};
                8'(`AFC_REG_RDATA): st_d.rdata = {23'h0, st_q.last_pop};
                8'(`AFC_REG_STATUS): st_d.rdata = status_word(st_q, flags);
                default: begin
                    st_d.rdata = 32'h0000_0000;
                    st_d.rresp = `AFC_RESP_SLVERR;
                end
            endcase
        end
        // Cascade input low selects single mode; high joins a chain.
        st_d.pins.cascade_n = st_q.cascade;
        st_d.pins.oe_n = !st_q.oe_q;
        // In a chain, first-load held low marks the first device.
        if (st_q.phase == AFC_IDLE && !st_q.pending) begin
            st_d.pins.rewind_n = !(st_q.cascade && st_q.first);
        end
        unique case (st_q.phase)
            AFC_IDLE: begin
                if (st_q.pending) begin
                    st_d.pending = 1'b0;
                    st_d.busy = 1'b1;
                    st_d.cnt = 16'(PULSE_CYC);
                    st_d.phase = AFC_ASSERT;
                    st_d.blocked = 1'b0;
                    unique case (st_q.op)
                        AFC_OP_RESET: st_d.pins.reset_n = 1'b0;
                        AFC_OP_REWIND: begin
                            if (st_q.cascade) begin
                                st_d.blocked = 1'b1;
                                st_d.phase = AFC_IDLE;
                                st_d.busy = 1'b0;
                            end else begin
                                st_d.pins.rewind_n = 1'b0;
                            end
                        end
                        AFC_OP_READ: begin
                            if (!flags.empty_n) begin
                                st_d.blocked = 1'b1;
                                st_d.phase = AFC_IDLE;
                                st_d.busy = 1'b0;
                            end else begin
                                st_d.pins.read_n = 1'b0;
                            end
                        end
                        AFC_OP_WRITE: begin
                            if (!flags.full_n || !st_q.reset_done) begin
                                st_d.blocked = 1'b1;
                                st_d.phase = AFC_IDLE;
                                st_d.busy = 1'b0;
                            end else begin
                                st_d.pins.write_n = 1'b0;
                            end
                        end
                    endcase
                end
            end
            AFC_ASSERT: begin
                st_d.cnt = st_q.cnt - 16'h0001;
                if (st_q.cnt <= 16'h0001) begin
                    if (!st_q.pins.read_n) begin
                        st_d.last_pop = pop_s;
                    end
                    if (!st_q.pins.reset_n) begin
                        st_d.reset_done = 1'b1;
                    end
                    st_d.pins.write_n = 1'b1;
                    st_d.pins.read_n = 1'b1;
                    st_d.pins.reset_n = 1'b1;
                    st_d.pins.rewind_n = 1'b1;
                    st_d.cnt = 16'(RECOV_CYC) + 16'h0002;
                    st_d.phase = AFC_RECOVER;
                end
            end
            AFC_RECOVER: begin
                // Extra two cycles let synchronised flags settle.
                st_d.cnt = st_q.cnt - 16'h0001;
                if (st_q.cnt <= 16'h0001) begin
                    st_d.busy = 1'b0;
                    st_d.phase = AFC_IDLE;
                end
            end
            default: st_d.phase = AFC_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
            st_q.phase <= AFC_IDLE;
            st_q.op <= AFC_OP_WRITE;
            st_q.pins <= '{write_n: 1'b1, read_n: 1'b1, reset_n: 1'b1, rewind_n: 1'b1,
                oe_n: 1'b1, cascade_n: 1'b0, data: 9'h000};
        end else begin
            st_q <= st_d;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
    assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign write_n = st_q.pins.write_n;
    assign read_n = st_q.pins.read_n;
    assign master_reset_n = st_q.pins.reset_n;
    assign first_load_rewind_n = st_q.pins.rewind_n;
    assign oe_n = st_q.pins.oe_n;
    assign cascade_in_n = st_q.pins.cascade_n;
    assign push_data = st_q.pins.data;
endmodule // afc_host

//--- verification/afc_host_props.sv
// Checker for the device pins that the buffer controller drives.
// Assumes it is bound into afc_host and sees only the ports of that module.
`timescale 1ns/100ps
module afc_host_props
    import afc_pkg::*;
#(
    parameter int PULSE_CYC = 5
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic write_n,
    input wire logic read_n,
    input wire logic master_reset_n,
    input wire logic first_load_rewind_n,
    input wire logic cascade_in_n,
    input wire logic [8:0] push_data
);
    // ------------------------------------------------------------
    // Counter of consecutive cycles with a strobe held low.
    // ------------------------------------------------------------
    logic [7:0] low_q;
    logic [7:0] low_d;
    always_comb begin
        low_d = (write_n && read_n && master_reset_n) ? 8'h00 : low_q + 8'h01;
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_idle;
        write_n && read_n;
    endsequence
    AST_RESET_IDLE: assert property (!master_reset_n |-> s_idle)
        else $error("strobe low during device reset");
    AST_REWIND_IDLE: assert property ($fell(first_load_rewind_n) |-> s_idle)
        else $error("strobe low when rewind falls");
    AST_RESET_WIDTH: assert property ($rose(master_reset_n) |-> low_q == PULSE_CYC)
        else $error("device reset pulse has wrong width");
    AST_WRITE_WIDTH: assert property ($rose(write_n) |-> low_q == PULSE_CYC)
        else $error("write pulse has wrong width");
    AST_READ_WIDTH: assert property ($rose(read_n) |-> low_q == PULSE_CYC)
        else $error("read pulse has wrong width");
    AST_ONE_STROBE: assert property (!write_n |-> read_n && master_reset_n)
        else $error("two strobes low together");
    AST_DATA_HOLD: assert property (!write_n |-> $stable(push_data))
        else $error("write data moved during write pulse");
    AST_REWIND_PULSE: assert property ($fell(first_load_rewind_n) && !cascade_in_n
        |-> ##PULSE_CYC first_load_rewind_n)
        else $error("rewind pulse has wrong width");
endmodule // afc_host_props
bind afc_host afc_host_props #(.PULSE_CYC(PULSE_CYC)) i_props (.sys_clk, .arst_n, .write_n,
    .read_n, .master_reset_n, .first_load_rewind_n, .cascade_in_n, .push_data);

//--- verification/afc_fifo_model.sv
// Behavioural model of the strobe-driven buffer device.
// Assumes the controller drives its strobes and reads its flags.
`timescale 1ns/100ps
module afc_fifo_model #(
    parameter int DEPTH = 64
) (
    input wire logic write_n,
    input wire logic read_n,
    input wire logic master_reset_n,
    input wire logic first_load_rewind_n,
    input wire logic oe_n,
    input wire logic cascade_in_n,
    input wire logic [8:0] push_data,
    output logic [8:0] pop_data,
    output logic full_flag_n,
    output logic empty_flag_n,
    output logic near_limit_flag_n,
    output logic cascade_out_half_n
);
    // ------------------------------------------------------------
    // Storage, pointers and flags.
    // ------------------------------------------------------------
    logic [8:0] mem_q [DEPTH];
    logic [8:0] word_q = 9'h000;
    int unsigned wr_q = 0;
    int unsigned rd_q = 0;
    bit rst_seen = 1'b0;
    bit rd_ok = 1'b0;
    int cnt;
    assign cnt = int'(wr_q - rd_q);
    always @(negedge master_reset_n) begin
        wr_q = 0;
        rd_q = 0;
        rst_seen = 1'b1;
    end
    always @(posedge write_n) begin
        if (rst_seen && master_reset_n && cnt < DEPTH) begin
            mem_q[wr_q % DEPTH] = push_data;
            wr_q++;
        end
    end
    always @(negedge read_n) begin
        rd_ok = cnt > 0;
        word_q = mem_q[rd_q % DEPTH];
    end
    always @(posedge read_n) begin
        if (rd_ok) begin
            rd_q++;
        end
        rd_ok = 1'b0;
    end
    always @(negedge first_load_rewind_n) begin
        if (!cascade_in_n) begin
            rd_q = wr_q - wr_q % DEPTH;
        end
    end
    assign pop_data = (!read_n && !oe_n) ? word_q : ~word_q;
    assign full_flag_n = cnt != DEPTH;
    assign empty_flag_n = cnt != 0;
    assign near_limit_flag_n = !(cnt < DEPTH / 8 || cnt > DEPTH * 7 / 8);
    assign cascade_out_half_n = cascade_in_n ?
        !(!write_n && wr_q % DEPTH == DEPTH - 1) : !(cnt > DEPTH / 2);
endmodule // afc_fifo_model

//--- verification/testbench.sv
// Self-checking bench for the buffer controller over AXI4-Lite.
// Assumes the device model stands on the controller's pins.
`timescale 1ns/100ps
`include "afc_defs.svh"
module testbench;
    // ------------------------------------------------------------
    // Signals, instances and bus tasks.
    // ------------------------------------------------------------
    localparam int DEPTH = 64;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd_v;
    logic write_n, read_n, master_reset_n, first_load_rewind_n, oe_n, cascade_in_n;
    logic [8:0] push_data, pop_data;
    logic full_flag_n, empty_flag_n, near_limit_flag_n, cascade_out_half_n;
    int failures = 0;
    int n_tests = 0;
    always #5 sys_clk = ~sys_clk;
    afc_host i_dut (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_n, .read_n,
        .master_reset_n, .first_load_rewind_n, .oe_n, .cascade_in_n, .push_data, .pop_data,
        .full_flag_n, .empty_flag_n, .near_limit_flag_n, .cascade_out_half_n);
    afc_fifo_model #(.DEPTH(DEPTH)) i_dev (.write_n, .read_n, .master_reset_n,
        .first_load_rewind_n, .oe_n, .cascade_in_n, .push_data, .pop_data, .full_flag_n,
        .empty_flag_n, .near_limit_flag_n, .cascade_out_half_n);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge sys_clk);
            if (aw_p && s_axi_awready) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge sys_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge sys_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic op(input logic [31:0] ctrl);
        axi_wr(`AFC_REG_CTRL, ctrl, rsp);
        for (int i = 0; i < 40; i++) begin
            axi_rd(`AFC_REG_STATUS, rd_v, rsp);
            if (rd_v[4] === 1'b0) break;
        end
        chk(rd_v[4], 1'b0);
    endtask
    task automatic put(input logic [8:0] w);
        axi_wr(`AFC_REG_WDATA, {23'h0, w}, rsp);
        op(32'h1);
    endtask
    task automatic take(input logic [8:0] w, input int left);
        op(32'h42);
        chk(rd_v[3:0], exp_flags(left));
        axi_rd(`AFC_REG_RDATA, rd_v, rsp);
        chk(rd_v[8:0], w);
    endtask
    function automatic logic [3:0] exp_flags(input int c);
        return {c != DEPTH, c != 0, !(c < DEPTH / 8 || c > DEPTH * 7 / 8), c <= DEPTH / 2};
    endfunction
    task automatic final_report;
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        final_report;
    end
    // ------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        op(32'h1);
        chk(rd_v[6], 1'b1);
        op(32'h4);
        chk(rd_v[5:0], {2'b10, exp_flags(0)});
        for (int i = 0; i < DEPTH; i++) begin
            put(9'(i * 37 + 5));
            chk({rd_v[6], rd_v[3:0]}, {1'b0, exp_flags(i + 1)});
        end
        put(9'h1aa);
        chk(rd_v[6], 1'b1);
        for (int i = 0; i < DEPTH; i++) take(9'(i * 37 + 5), DEPTH - 1 - i);
        op(32'h42);
        chk(rd_v[6], 1'b1);
        for (int i = 0; i < 3; i++) put(9'(9'h100 + i));
        take(9'h100, 2);
        take(9'h101, 1);
        op(32'h8);
        chk(rd_v[3:0], exp_flags(3));
        op(32'h2);
        chk(oe_n, 1'b1);
        take(9'h101, 1);
        op(32'h4);
        chk(rd_v[3:0], exp_flags(0));
        op(32'h18);
        chk({rd_v[6], cascade_in_n, first_load_rewind_n}, 3'b111);
        op(32'h30);
        chk(first_load_rewind_n, 1'b0);
        op(32'h0);
        chk({cascade_in_n, first_load_rewind_n}, 2'b01);
        axi_rd(32'h10, rd_v, rsp);
        chk({rsp, rd_v}, {`AFC_RESP_SLVERR, 32'h0});
        axi_wr(32'h10, 32'h0, rsp);
        chk(rsp, `AFC_RESP_SLVERR);
        final_report;
    end
endmodule // testbench
